// ### rtl/log_page_defs.svh
// offsets, field positions, fixed values and sizes of the three log pages
// assumes byte offsets within one 512-byte page, log addresses as 8-bit codes
// Summary of operation
// - Directory page offset 0 holds version word 0001h.
// - Version word 0000h means no directory; shown only when none exists.
// - Directory holds each log's sector count, low byte at 2N, high at 2N+1.
// - Host-specific logs 80h to 9Fh are listed as 16 sectors each.
// - Errors from faulty commands are never recorded in the error log.
// - Error page byte 0 is version 01h, byte 1 reserved.
// - Error index at 02h/03h, low first, newest entry, zero when empty, 0-4.
// - Four 124-byte error entries at 04h, 80h, FCh and 178h.
// - Error entries form a ring; fifth error overwrites the first.
// - Never-used error entries read as zero bytes.
// - Entry is five 18-byte command records then a 34-byte error record at 5Ah.
// - Command record byte order ends with command, reserved, 4-byte ms timestamp.
// - Command record pair: low byte newest write, high byte value before it.
// - Error record: error, register pairs, device, status, vendor, state, hours.
// - Error record pair: low byte read with control bit 7 clear, high set.
// - State low nibble: 0 unknown,1 sleep,2 standby,3 active,4 offline/self-test.
// - Lifetime device error count at 1F4h, faulty commands excluded, saturating.
// - Self-test page: index at 02h/03h, nineteen 26-byte descriptors from 04h.
// - Self-test ring: the nineteenth test overwrites descriptor one.
// - Never-used self-test descriptors read as zero bytes.
// - Self-test log holds both 48-bit and 28-bit addressed test entries.
// - Last byte of each history page makes all 512 bytes sum to zero.
// - Self-test index points at newest, zero when none, within 0 to 17.
// - Self-test page byte 0 holds revision 01h.
`ifndef LOG_PAGE_DEFS_SVH
`define LOG_PAGE_DEFS_SVH
`define LOG_DIR 8'h00
`define LOG_ERR 8'h03
`define LOG_ST 8'h07
`define LOG_CMDERR 8'h10
`define LOG_PHY 8'h11
`define LOG_HOST_LO 8'h80
`define LOG_HOST_HI 8'h9f
`define DIR_VERSION 16'h0001
`define DIR_NONE 16'h0000
`define HOST_SECTORS 8'h10
`define PAGE_SECTORS 8'h01
`define ERR_VERSION 8'h01
`define ST_VERSION 8'h01
`define ENTRY_BASE 4
`define ERR_ENTRY_BYTES 124
`define ERR_SLOTS 4
`define ST_ENTRY_BYTES 26
`define ST_SLOTS 19
`define OFF_VERSION 9'h000
`define OFF_IDX_LO 9'h002
`define OFF_IDX_HI 9'h003
`define OFF_CNT_LO 9'h1f4
`define OFF_CNT_HI 9'h1f5
`define OFF_CHECKSUM 9'h1ff
`define ERRCNT_MAX 16'hffff
`endif

// ### rtl/log_page_pkg.sv
// types of the log page builder: sequencer states and entry layouts
// multi-byte fields are byte arrays whose element 0 is the least significant byte
package log_page_pkg;
    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_ERR = 3'h2,
        S_ST = 3'h4
    } seq_e;
    typedef enum logic [3:0] {
        DS_UNKNOWN = 4'h0,
        DS_SLEEP = 4'h1,
        DS_STANDBY = 4'h2,
        DS_ACTIVE = 4'h3,
        DS_OFFLINE = 4'h4
    } dev_state_e;
    // 18 bytes in page order; *_cur newest write, *_prev value before it
    typedef struct packed {
        logic [7:0] dev_ctl;
        logic [7:0] feat_cur, feat_prev, cnt_cur, cnt_prev, secn_cur, secn_prev;
        logic [7:0] cyll_cur, cyll_prev, cylh_cur, cylh_prev, device, command, rsv;
        logic [0:3][7:0] ts_ms;
    } cmd_rec_s;
    // 34 bytes; *_lo read with control bit 7 clear, *_hi with it set
    typedef struct packed {
        logic [7:0] rsv, error;
        logic [7:0] cnt_lo, cnt_hi, secn_lo, secn_hi, cyll_lo, cyll_hi, cylh_lo, cylh_hi;
        logic [7:0] device, status;
        logic [0:18][7:0] vendor;
        logic [3:0] state_vendor;
        dev_state_e state;
        logic [0:1][7:0] hours;
    } err_rec_s;
    typedef struct packed {
        cmd_rec_s [0:4] cmd;
        err_rec_s err;
    } err_entry_s;
    // 26 bytes; a 28-bit test leaves lba bytes 4 and 5 at zero
    typedef struct packed {
        logic [7:0] number, status;
        logic [0:1][7:0] hours;
        logic [7:0] checkpoint;
        logic [0:5][7:0] lba;
        logic [0:14][7:0] vendor;
    } st_desc_s;
endpackage

// ### rtl/page_sum_if.sv
// running byte sum of one history page between the builder and its summer
// assumes one update per clock at most
`timescale 1ns/10ps
`default_nettype none
interface page_sum_if;
    logic upd;
    logic [7:0] old_byte;
    logic [7:0] new_byte;
    logic [7:0] fixed_sum;
    logic [7:0] chk;
    modport builder (output upd, output old_byte, output new_byte, output fixed_sum,
        input chk);
    modport summer (input upd, input old_byte, input new_byte, input fixed_sum,
        output chk);
endinterface
`default_nettype wire

// ### rtl/log_page_sum.sv
// checksum keeper for one 512-byte page
// assumes the page body starts all zero at reset and changes one byte per update
`timescale 1ns/10ps
`default_nettype none
module log_page_sum (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // page sum link
    page_sum_if.summer sp
);
    typedef struct packed {
        logic [7:0] body_sum;
    } sum_state_s;
    sum_state_s cur, next_cur;

    // replacing a byte only moves the sum by the difference, no page rescan
    always_comb begin
        next_cur = cur;
        if (sp.upd) begin
            next_cur.body_sum = cur.body_sum + sp.new_byte - sp.old_byte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign sp.chk = 8'h00 - (cur.body_sum + sp.fixed_sum);

    // checksum plus header sum is minus the body sum, so it moves by old minus new
    a_sum_follows_update: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sp.upd |=> 8'(sp.chk + sp.fixed_sum) == 8'($past(sp.chk) + $past(sp.fixed_sum)
            - $past(sp.new_byte) + $past(sp.old_byte))
    ) else $error("page checksum did not follow the byte update");
endmodule // log_page_sum
`default_nettype wire

// ### rtl/log_page_builder.sv
// keeps the error and self-test history pages and serves bytes of the
// directory, error and self-test pages to the log reader
// assumes firmware presents one entry at a time and reads one byte per request
`timescale 1ns/10ps
`default_nettype none
`include "log_page_defs.svh"
module log_page_builder #(
    parameter bit DIR_PRESENT = 1'b1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // error event
    input wire logic err_valid_i,
    input wire logic err_faulty_i,
    input wire log_page_pkg::err_entry_s err_entry_i,
    output logic err_ready_o,
    // self-test completion
    input wire logic st_valid_i,
    input wire log_page_pkg::st_desc_s st_desc_i,
    output logic st_ready_o,
    // page byte read
    input wire logic rd_en_i,
    input wire logic [7:0] rd_log_i,
    input wire logic [8:0] rd_offs_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o
);
    localparam int CAPW = `ERR_ENTRY_BYTES * 8;
    localparam int STW = `ST_ENTRY_BYTES * 8;

    typedef struct packed {
        log_page_pkg::seq_e fsm;
        logic [6:0] pos;
        logic [2:0] err_idx;
        logic [15:0] err_cnt;
        logic [4:0] st_idx;
        logic st_any;
        logic [CAPW-1:0] cap;
        logic [7:0] rd_data;
        logic rd_valid;
    } build_state_s;
    build_state_s cur, next_cur;

    logic [7:0] err_mem [0:511];
    logic [7:0] st_mem [0:511];
    logic err_we, st_we;
    logic [8:0] wr_addr;
    logic [7:0] wr_byte;
    logic [1:0] err_slot;
    logic [4:0] st_slot;

    page_sum_if err_sp ();
    page_sum_if st_sp ();

    function automatic logic [8:0] slot_addr(input int size, input int slot, input int pos);
        slot_addr = 9'(`ENTRY_BASE + size * slot + pos);
    endfunction

    function automatic logic [7:0] cap_byte(input logic [CAPW-1:0] cap, input logic [6:0] pos);
        cap_byte = cap[(CAPW - 8) - 8 * int'(pos) +: 8];
    endfunction

    function automatic logic [7:0] dir_byte(input logic [8:0] offs);
        logic [7:0] addr;
        addr = offs[8:1];
        dir_byte = 8'h00;
        if (offs == `OFF_VERSION) begin
            dir_byte = DIR_PRESENT ? 8'(`DIR_VERSION) : 8'(`DIR_NONE);
        end else if (DIR_PRESENT && !offs[0] && addr != `LOG_DIR) begin
            if (addr >= `LOG_HOST_LO && addr <= `LOG_HOST_HI) begin
                dir_byte = `HOST_SECTORS;
            end else if (addr == `LOG_ERR || addr == `LOG_ST || addr == `LOG_CMDERR
                    || addr == `LOG_PHY) begin
                dir_byte = `PAGE_SECTORS;
            end
        end
    endfunction

    // next slot of each ring: error index is 1-based, self-test index 0-based
    // the nineteenth test wraps to descriptor one, so descriptor nineteen stays zero
    assign err_slot = (cur.err_idx == 3'(`ERR_SLOTS)) ? 2'h0 : cur.err_idx[1:0];
    assign st_slot = !cur.st_any ? 5'h00 :
        (cur.st_idx == 5'(`ST_SLOTS - 2)) ? 5'h00 : cur.st_idx + 5'h01;

    always_comb begin
        log_page_pkg::err_entry_s e;
        logic [7:0] rb;
        e = err_entry_i;
        rb = 8'h00;
        next_cur = cur;
        err_we = 1'b0;
        st_we = 1'b0;
        wr_addr = 9'h000;
        wr_byte = 8'h00;
        unique case (cur.fsm)
            log_page_pkg::S_IDLE: begin
                if (err_valid_i) begin
                    // faulty commands are acknowledged but leave no trace
                    if (!err_faulty_i) begin
                        for (int i = 0; i < 5; i++) begin
                            e.cmd[i].rsv = 8'h00;
                        end
                        e.err.rsv = 8'h00;
                        next_cur.cap = e;
                        next_cur.pos = 7'h00;
                        next_cur.fsm = log_page_pkg::S_ERR;
                    end
                end else if (st_valid_i) begin
                    next_cur.cap = {st_desc_i, {(CAPW - STW){1'b0}}};
                    next_cur.pos = 7'h00;
                    next_cur.fsm = log_page_pkg::S_ST;
                end
            end
            log_page_pkg::S_ERR: begin
                err_we = 1'b1;
                wr_addr = slot_addr(`ERR_ENTRY_BYTES, int'(err_slot), int'(cur.pos));
                wr_byte = cap_byte(cur.cap, cur.pos);
                if (cur.pos == 7'(`ERR_ENTRY_BYTES - 1)) begin
                    next_cur.fsm = log_page_pkg::S_IDLE;
                    next_cur.err_idx = 3'(err_slot) + 3'h1;
                    if (cur.err_cnt != `ERRCNT_MAX) begin
                        next_cur.err_cnt = cur.err_cnt + 16'h0001;
                    end
                end else begin
                    next_cur.pos = cur.pos + 7'h01;
                end
            end
            log_page_pkg::S_ST: begin
                st_we = 1'b1;
                wr_addr = slot_addr(`ST_ENTRY_BYTES, int'(st_slot), int'(cur.pos));
                wr_byte = cap_byte(cur.cap, cur.pos);
                if (cur.pos == 7'(`ST_ENTRY_BYTES - 1)) begin
                    next_cur.fsm = log_page_pkg::S_IDLE;
                    next_cur.st_idx = st_slot;
                    next_cur.st_any = 1'b1;
                end else begin
                    next_cur.pos = cur.pos + 7'h01;
                end
            end
            default: begin
                next_cur.fsm = log_page_pkg::S_IDLE;
            end
        endcase

        // header fields are muxed over the body; unwritten bytes stay zero
        if (rd_log_i == `LOG_DIR) begin
            rb = dir_byte(rd_offs_i);
        end else if (rd_log_i == `LOG_ERR) begin
            unique case (rd_offs_i)
                `OFF_VERSION: rb = `ERR_VERSION;
                `OFF_IDX_LO: rb = {5'h00, cur.err_idx};
                `OFF_IDX_HI: rb = 8'h00;
                `OFF_CNT_LO: rb = cur.err_cnt[7:0];
                `OFF_CNT_HI: rb = cur.err_cnt[15:8];
                `OFF_CHECKSUM: rb = err_sp.chk;
                default: rb = err_mem[rd_offs_i];
            endcase
        end else if (rd_log_i == `LOG_ST) begin
            unique case (rd_offs_i)
                `OFF_VERSION: rb = `ST_VERSION;
                `OFF_IDX_LO: rb = {3'h0, cur.st_idx};
                `OFF_IDX_HI: rb = 8'h00;
                `OFF_CHECKSUM: rb = st_sp.chk;
                default: rb = st_mem[rd_offs_i];
            endcase
        end
        next_cur.rd_valid = rd_en_i;
        if (rd_en_i) begin
            next_cur.rd_data = rb;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '{fsm: log_page_pkg::S_IDLE, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // pages are cleared while reset is held so unused entries read as zeros
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 512; i++) begin
                err_mem[i] <= 8'h00;
                st_mem[i] <= 8'h00;
            end
        end else if (err_we) begin
            err_mem[wr_addr] <= wr_byte;
        end else if (st_we) begin
            st_mem[wr_addr] <= wr_byte;
        end
    end

    // checksum follows every body write and header change
    assign err_sp.upd = err_we;
    assign err_sp.old_byte = err_mem[wr_addr];
    assign err_sp.new_byte = wr_byte;
    assign err_sp.fixed_sum = `ERR_VERSION + {5'h00, cur.err_idx} + cur.err_cnt[7:0]
        + cur.err_cnt[15:8];
    assign st_sp.upd = st_we;
    assign st_sp.old_byte = st_mem[wr_addr];
    assign st_sp.new_byte = wr_byte;
    assign st_sp.fixed_sum = `ST_VERSION + {3'h0, cur.st_idx};

    log_page_sum err_sum (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sp(err_sp.summer)
    );

    log_page_sum st_sum (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sp(st_sp.summer)
    );

    // a new entry waits until the previous one is fully written
    assign err_ready_o = (cur.fsm == log_page_pkg::S_IDLE);
    assign st_ready_o = (cur.fsm == log_page_pkg::S_IDLE) && !err_valid_i;
    assign rd_data_o = cur.rd_data;
    assign rd_valid_o = cur.rd_valid;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_err_idx_range: assert property (
        cur.err_idx <= 3'd4
    ) else $error("error log index out of range");

    a_st_idx_range: assert property (
        cur.st_idx <= 5'd18 && (cur.st_any || cur.st_idx == 5'd0)
    ) else $error("self-test index out of range");

    a_cnt_saturates: assert property (
        cur.err_cnt == 16'hffff |=> cur.err_cnt == 16'hffff
    ) else $error("device error count wrapped");

    a_faulty_ignored: assert property (
        cur.fsm == log_page_pkg::S_IDLE && err_valid_i && err_faulty_i
        |=> $stable(cur.err_cnt) && $stable(cur.err_idx) && cur.fsm == log_page_pkg::S_IDLE
    ) else $error("faulty command changed the error log");

    a_err_ring_step: assert property (
        cur.fsm == log_page_pkg::S_IDLE && err_valid_i && !err_faulty_i
        |-> ##125 cur.err_idx == (($past(cur.err_idx, 125) == 3'd4) ? 3'd1
            : $past(cur.err_idx, 125) + 3'd1)
    ) else $error("error index did not advance around the ring");

    a_st_ring_step: assert property (
        cur.fsm == log_page_pkg::S_IDLE && st_valid_i && !err_valid_i && cur.st_any
        |-> ##27 cur.st_idx == (($past(cur.st_idx, 27) == 5'd17) ? 5'd0
            : $past(cur.st_idx, 27) + 5'd1)
    ) else $error("self-test index did not advance around the ring");

    a_err_slot_window: assert property (
        err_we |-> wr_addr >= 9'h004 && wr_addr <= 9'h1f3
    ) else $error("error entry write outside the entry area");

    a_dir_version: assert property (
        rd_en_i && rd_log_i == 8'h00 && rd_offs_i == 9'h000
        |=> rd_valid_o && rd_data_o == (DIR_PRESENT ? 8'h01 : 8'h00)
    ) else $error("directory version byte wrong");

    a_host_sectors: assert property (
        rd_en_i && rd_log_i == 8'h00 && rd_offs_i[8:6] == 3'b100 && !rd_offs_i[0]
        |=> rd_data_o == (DIR_PRESENT ? 8'h10 : 8'h00)
    ) else $error("host log sector count not sixteen");
endmodule // log_page_builder
`default_nettype wire

// ### testbench/log_host_model.sv
// host reader of log pages over the byte read port
// assumes each request is answered exactly one clock later
`timescale 1ns/10ps
`default_nettype none
module log_host_model (
    // clock
    input wire logic clk_i,
    // page byte read
    output logic rd_en_o,
    output logic [7:0] rd_log_o,
    output logic [8:0] rd_offs_o,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i
);
    logic [7:0] page [512];
    logic bad_valid;
    logic no_dir;
    initial begin
        rd_en_o = 1'b0;
        rd_log_o = 8'h5a;
        rd_offs_o = 9'h0a5;
        bad_valid = 1'b0;
        no_dir = 1'b0;
    end
    // idle lines flip so a stale address never looks held
    task automatic release_bus();
        rd_en_o = 1'b0;
        rd_log_o = ~rd_log_o;
        rd_offs_o = ~rd_offs_o;
    endtask
    // byte k-1 comes back while offset k is presented
    task automatic read_page(input logic [7:0] log);
        for (int k = 0; k <= 512; k++) begin
            @(negedge clk_i);
            if (k > 0) begin
                page[k - 1] = rd_data_i;
                bad_valid |= (rd_valid_i !== 1'b1);
            end
            if (k < 512) begin
                rd_en_o = 1'b1;
                rd_log_o = log;
                rd_offs_o = 9'(k);
            end else begin
                release_bus();
            end
        end
        no_dir = ({page[1], page[0]} === 16'h0000);
    endtask
    task automatic read_byte(input logic [7:0] log, input logic [8:0] offs,
        output logic [7:0] b);
        @(negedge clk_i);
        rd_en_o = 1'b1;
        rd_log_o = log;
        rd_offs_o = offs;
        @(negedge clk_i);
        b = rd_data_i;
        bad_valid |= (rd_valid_i !== 1'b1);
        release_bus();
    endtask
endmodule // log_host_model
`default_nettype wire

// ### testbench/log_page_builder_tb_top.sv
// bench of the log page builder: reset pages, directory, error and self-test rings
// assumes log_host_model as the page reader
`timescale 1ns/10ps
`default_nettype none
`include "log_page_defs.svh"
module log_page_builder_tb_top;
    logic clk_i, rst_i, err_valid_i, err_faulty_i, st_valid_i, use_b;
    log_page_pkg::err_entry_s err_entry_i;
    log_page_pkg::st_desc_s st_desc_i;
    logic err_ready_o, st_ready_o, rd_valid_o, rd_valid_b, rd_en_i;
    logic [7:0] rd_log_i, rd_data_o, rd_data_b;
    logic [8:0] rd_offs_i;
    logic [7:0] exp_err [512];
    logic [7:0] exp_st [512];
    logic [7:0] exp_dir [512];
    logic [7:0] zero [512];
    logic [15:0] cnt;
    int failures, checked, nerr, nst;

    log_page_builder dut (.clk_i(clk_i), .rst_i(rst_i), .err_valid_i(err_valid_i),
        .err_faulty_i(err_faulty_i), .err_entry_i(err_entry_i), .err_ready_o(err_ready_o),
        .st_valid_i(st_valid_i), .st_desc_i(st_desc_i), .st_ready_o(st_ready_o),
        .rd_en_i(rd_en_i), .rd_log_i(rd_log_i), .rd_offs_i(rd_offs_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o));
    log_page_builder #(.DIR_PRESENT(1'b0)) dut_nodir (.clk_i(clk_i), .rst_i(rst_i),
        .err_valid_i(err_valid_i), .err_faulty_i(err_faulty_i), .err_entry_i(err_entry_i),
        .err_ready_o(), .st_valid_i(st_valid_i), .st_desc_i(st_desc_i), .st_ready_o(),
        .rd_en_i(rd_en_i), .rd_log_i(rd_log_i), .rd_offs_i(rd_offs_i),
        .rd_data_o(rd_data_b), .rd_valid_o(rd_valid_b));
    log_host_model host (.clk_i(clk_i), .rd_en_o(rd_en_i), .rd_log_o(rd_log_i),
        .rd_offs_o(rd_offs_i), .rd_data_i(use_b ? rd_data_b : rd_data_o),
        .rd_valid_i(use_b ? rd_valid_b : rd_valid_o));

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check_byte(input logic [7:0] log, input logic [8:0] offs,
        input logic [7:0] ex);
        logic [7:0] b;
        host.read_byte(log, offs, b);
        cmp8(b, ex);
    endtask
    // sum set: last byte must cancel the other 511
    task automatic check_page(input logic [7:0] log, input logic [7:0] ex [512], input bit sum);
        logic [7:0] s;
        s = 8'h00;
        host.read_page(log);
        cmp8({7'h00, host.bad_valid}, 8'h00);
        for (int k = 0; k < 511; k++) begin
            cmp8(host.page[k], ex[k]);
            s = s + ex[k];
        end
        cmp8(host.page[511], sum ? 8'h00 - s : ex[511]);
    endtask
    function automatic log_page_pkg::err_entry_s make_err(input logic [7:0] s);
        logic [991:0] v;
        log_page_pkg::err_entry_s e;
        for (int k = 0; k < 124; k++) v[991 - 8 * k -: 8] = s + 8'(k * 7);
        e = v;
        for (int i = 0; i < 5; i++) e.cmd[i].rsv = 8'h00;
        e.err.rsv = 8'h00;
        e.err.state = log_page_pkg::dev_state_e'(nerr % 5);
        return e;
    endfunction
    task automatic send_err(input log_page_pkg::err_entry_s e, input logic faulty);
        logic [991:0] v;
        int w, slot;
        v = e;
        w = 0;
        err_entry_i = e;
        err_faulty_i = faulty;
        err_valid_i = 1'b1;
        #1;
        cmp8({7'h00, st_ready_o}, 8'h00);
        @(negedge clk_i);
        err_valid_i = 1'b0;
        while (err_ready_o !== 1'b1 && w < 300) begin
            w++;
            @(negedge clk_i);
        end
        cmp8(8'(w), faulty ? 8'h00 : 8'h7c);
        if (!faulty) begin
            slot = nerr % 4;
            nerr++;
            for (int k = 0; k < 124; k++) exp_err[4 + 124 * slot + k] = v[991 - 8 * k -: 8];
            if (cnt != 16'hffff) cnt++;
            exp_err[2] = 8'(slot + 1);
            {exp_err[501], exp_err[500]} = cnt;
        end
        check_byte(`LOG_ERR, 9'h002, exp_err[2]);
        check_byte(`LOG_ERR, 9'h003, 8'h00);
        check_byte(`LOG_ERR, 9'h1f4, exp_err[500]);
        check_byte(`LOG_ERR, 9'h1f5, exp_err[501]);
    endtask
    // the nineteenth test reuses descriptor one, so descriptor 19 stays zero
    task automatic send_st(input int n);
        logic [207:0] v;
        int w, slot;
        w = 0;
        for (int k = 0; k < 26; k++) v[207 - 8 * k -: 8] = 8'(n * 11 + k + 1);
        if (n % 2 == 0) v[135 -: 16] = 16'h0000;
        st_desc_i = v;
        st_valid_i = 1'b1;
        @(negedge clk_i);
        st_valid_i = 1'b0;
        while (st_ready_o !== 1'b1 && w < 300) begin
            w++;
            @(negedge clk_i);
        end
        cmp8(8'(w), 8'h1a);
        slot = nst % 18;
        nst++;
        for (int k = 0; k < 26; k++) exp_st[4 + 26 * slot + k] = v[207 - 8 * k -: 8];
        exp_st[2] = 8'(slot);
        check_byte(`LOG_ST, 9'h002, exp_st[2]);
        check_byte(`LOG_ST, 9'h003, 8'h00);
    endtask

    task automatic test_reset();
        cmp8({7'h00, err_ready_o}, 8'h01);
        check_page(`LOG_ERR, exp_err, 1'b1);
        check_page(`LOG_ST, exp_st, 1'b1);
    endtask
    task automatic test_dir();
        check_page(`LOG_DIR, exp_dir, 1'b0);
        cmp8({7'h00, host.no_dir}, 8'h00);
        use_b = 1'b1;
        check_page(`LOG_DIR, zero, 1'b0);
        cmp8({7'h00, host.no_dir}, 8'h01);
        use_b = 1'b0;
        check_byte(`LOG_CMDERR, 9'h000, 8'h00);
    endtask
    task automatic test_errors();
        for (int n = 0; n < 7; n++) send_err(make_err(8'(n * 37 + 5)), n == 2);
        check_page(`LOG_ERR, exp_err, 1'b1);
    endtask
    task automatic test_selftest();
        send_st(0);
        check_page(`LOG_ST, exp_st, 1'b1);
        for (int n = 1; n < 20; n++) send_st(n);
        check_page(`LOG_ST, exp_st, 1'b1);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // whole run is near 5000 cycles; this allows five times that
    initial begin
        #200000;
        failures++;
        final_report();
    end
    initial begin
        rst_i = 1'b1;
        err_valid_i = 1'b0;
        err_faulty_i = 1'b0;
        err_entry_i = '0;
        st_valid_i = 1'b0;
        st_desc_i = '0;
        use_b = 1'b0;
        cnt = 16'h0000;
        for (int k = 0; k < 512; k++) begin
            exp_err[k] = 8'h00;
            exp_st[k] = 8'h00;
            exp_dir[k] = 8'h00;
            zero[k] = 8'h00;
        end
        exp_err[0] = 8'h01;
        exp_st[0] = 8'h01;
        exp_dir[0] = 8'h01;
        exp_dir[6] = 8'h01;
        exp_dir[14] = 8'h01;
        exp_dir[32] = 8'h01;
        exp_dir[34] = 8'h01;
        for (int n = 128; n < 160; n++) exp_dir[2 * n] = 8'h10;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        test_reset();
        test_dir();
        test_errors();
        test_selftest();
        final_report();
    end
endmodule // log_page_builder_tb_top
`default_nettype wire
